// file: rrp_pkg.sv
// ==================================================================
// sequencer constants
package rrp_pkg;

  // ==================================================================
  // register map: printed offsets are indices, byte address = 4 * index
  localparam int unsigned ADDR_W    = 18;
  localparam int unsigned IDX_W     = ADDR_W - 2;
  localparam logic [15:0] IDX_PWR   = 16'hDF17;
  localparam logic [15:0] IDX_TMH   = 16'hDF20;
  localparam logic [15:0] IDX_TML   = 16'hDF21;
  localparam logic [15:0] IDX_MSKH  = 16'hDF22;
  localparam logic [15:0] IDX_MSKL  = 16'hDF23;

  // ==================================================================
  // field positions
  localparam int unsigned PWR_STAT  = 4;
  localparam int unsigned PWR_REQ   = 3;
  localparam int unsigned MSKH_BIAS = 6;

  // ==================================================================
  // reset values
  localparam logic       RST_REQ    = 1'b1;
  localparam logic       RST_STAT   = 1'b1;
  localparam logic [2:0] RST_DLY    = 3'h4;
  localparam logic [7:0] RST_TMH    = 8'h7A;
  localparam logic [7:0] RST_TML    = 8'h94;
  localparam logic [7:0] RST_MSKH   = 8'hBF;
  localparam logic [7:0] RST_MSKL   = 8'h7F;

  // ==================================================================
  // timing counts
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned US_PS         = 1000000;
  localparam int unsigned US_CYCLES_DEF = US_PS / CLK_PERIOD_PS;
  localparam logic [11:0] RX_STEP_US    = 12'h005;
  // filter calibration: 6.5 symbols of 16 us, kept as half symbols
  localparam int unsigned SYMBOL_US     = 16;
  localparam int unsigned CAL_HALF_SYM  = 13;
  localparam logic [11:0] CAL_US        = 12'(CAL_HALF_SYM * SYMBOL_US / 2);

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX_CAL, ST_RX_CHAIN, ST_RX_ON,
    ST_TX_LEAD, ST_TX_ON, ST_TX_TAIL
  } rrp_state_t;

  // regulator power-on delay in microseconds
  function automatic logic [11:0] reg_delay_us(input logic [2:0] sel);
    case (sel)
      3'h0:    reg_delay_us = 12'h000;
      3'h1:    reg_delay_us = 12'h01F;
      3'h2:    reg_delay_us = 12'h03F;
      3'h3:    reg_delay_us = 12'h07D;
      3'h4:    reg_delay_us = 12'h0FA;
      3'h5:    reg_delay_us = 12'h1F4;
      3'h6:    reg_delay_us = 12'h3E8;
      default: reg_delay_us = 12'h7D0;
    endcase
  endfunction

endpackage

// file: rrp_radio_power_seq.sv
// Operation
// RULE1 - regulator powered down while request bit is 1; bit resets to 1
// RULE2 - read-only status bit 4 follows request after delay; resets to 1
// RULE3 - three-bit delay selects 0..2000 us power-on delay; resets to 100
// RULE4 - demodulator and AGC enabled 5 us steps after RX chain; resets 011
// RULE5 - RX chain starts only after 6.5 symbol filter calibration
// RULE6 - RX/TX switch raised programmed us before TX; resets to 110
// RULE7 - PA powered up programmed us before TX; split four-bit count
// RULE8 - RX/TX switch dropped programmed us after last chip; resets 010
// RULE9 - PA and modulator off programmed us after last chip; resets 100
// RULE10 - upper mask bit 7 gates VGA peak detector reset, resets to 1
// RULE11 - upper mask bit 5 gates PA bias balun control line
// RULE12 - upper mask bit 4 gates RX/TX select line
// RULE13 - bits 2,1 gate PA path power-downs; both high powers mixers down
// RULE14 - bit 3 gates prescaler, bit 0 gates TX DAC power-down
// RULE15 - lower mask bits 6..0 gate seven receive/synth power-downs
// RULE16 - reserved power bits 7:5 and lower mask bit 7 read zero
// RULE17 - each mask bit ANDs with its sequenced line
// RULE18 - timings counted by clock-derived timer restarted on its trigger
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rrp_radio_power_seq #(
  parameter int unsigned US_CYCLES = rrp_pkg::US_CYCLES_DEF
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [rrp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       rx_req,
  input  wire logic                       tx_req,
  input  wire logic                       tx_last_chip,
  output logic                            regulator_off_request,
  output logic                            delayed_regulator_off_status,
  output logic                            rx_chain_en,
  output logic                            demod_agc_en,
  output logic                            tx_en,
  output logic                            modulator_en,
  output logic                            gain_amp_peak_reset_n,
  output logic                            pa_bias_switch_ctrl,
  output logic                            rxtx_select,
  output logic                            prescaler_off,
  output logic                            pa_neg_path_off,
  output logic                            pa_pos_path_off,
  output logic                            up_mixer_off,
  output logic                            tx_dac_off,
  output logic                            filter_cal_osc_off,
  output logic                            charge_pump_off,
  output logic                            synth_vco_off,
  output logic                            rx_converters_off,
  output logic                            gain_amp_off,
  output logic                            rx_filter_off,
  output logic                            front_end_off
);
  import rrp_pkg::*;

  // ==================================================================
  // elaboration check
  if (US_CYCLES < 2) begin : g_bad_us
    $error("US_CYCLES must be at least 2");
  end

  localparam int unsigned PS_W = $clog2(US_CYCLES);
  localparam logic [PS_W-1:0] PS_LAST = PS_W'(US_CYCLES - 1);

  // ==================================================================
  // registers
  logic [2:0]  regulator_on_delay_select;
  logic [7:0]  tmh;
  logic [7:0]  tml;
  logic [6:0]  mskh;   // register bit 6 is not stored and reads zero; mskh[6] holds bit 7
  logic [6:0]  mskl;

  logic [2:0]  rx_chain_to_demod_time;
  logic [2:0]  switch_lead_time;
  logic [3:0]  pa_on_lead_time;
  logic [2:0]  tx_end_switch_off_time;
  logic [2:0]  tx_end_pa_off_time;

  assign rx_chain_to_demod_time = tmh[7:5];
  assign switch_lead_time       = tmh[4:2];
  assign pa_on_lead_time        = {tmh[1:0], tml[7:6]}; // RULE7
  assign tx_end_switch_off_time = tml[5:3];
  assign tx_end_pa_off_time     = tml[2:0];

  // ==================================================================
  // apb slave: zero wait states, read data captured in setup cycle
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == IDX_W'(idx));
  endfunction

  logic       wr;
  logic       mapped;
  logic [7:0] rd_val;

  assign wr      = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // read mux; reserved bits come back as zero
  always_comb begin
    mapped = 1'b1;
    rd_val = 8'h00;
    if (hit(paddr, IDX_PWR)) begin
      rd_val = {3'h0, delayed_regulator_off_status, regulator_off_request,
                regulator_on_delay_select}; // RULE16
    end else if (hit(paddr, IDX_TMH)) begin
      rd_val = tmh;
    end else if (hit(paddr, IDX_TML)) begin
      rd_val = tml;
    end else if (hit(paddr, IDX_MSKH)) begin
      rd_val = {mskh[6], 1'b0, mskh[5:0]};
    end else if (hit(paddr, IDX_MSKL)) begin
      rd_val = {1'b0, mskl}; // RULE16
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= {24'h00_0000, rd_val};
    end
  end

  // register writes; status bit is never written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_off_request     <= RST_REQ;
      regulator_on_delay_select <= RST_DLY;
      tmh                       <= RST_TMH;
      tml                       <= RST_TML;
      mskh                      <= {RST_MSKH[7], RST_MSKH[5:0]};
      mskl                      <= RST_MSKL[6:0];
    end else if (wr) begin
      if (hit(paddr, IDX_PWR)) begin
        regulator_off_request     <= pwdata[PWR_REQ]; // RULE1
        regulator_on_delay_select <= pwdata[2:0];
      end else if (hit(paddr, IDX_TMH)) begin
        tmh <= pwdata[7:0];
      end else if (hit(paddr, IDX_TML)) begin
        tml <= pwdata[7:0];
      end else if (hit(paddr, IDX_MSKH)) begin
        mskh <= {pwdata[7], pwdata[5:0]};
      end else if (hit(paddr, IDX_MSKL)) begin
        mskl <= pwdata[6:0];
      end
    end
  end

  // ==================================================================
  // regulator status: power-down shows at once, power-up after delay
  logic            req_q;
  logic            reg_wait;
  logic [PS_W-1:0] reg_ps;
  logic [11:0]     reg_us;
  logic [11:0]     reg_dly;

  assign reg_dly = reg_delay_us(regulator_on_delay_select); // RULE3

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q                        <= RST_REQ;
      reg_wait                     <= 1'b0;
      reg_ps                       <= '0;
      reg_us                       <= 12'h000;
      delayed_regulator_off_status <= RST_STAT;
    end else begin
      req_q <= regulator_off_request;
      if (regulator_off_request) begin
        // going down needs no settling time
        reg_wait                     <= 1'b0;
        delayed_regulator_off_status <= 1'b1; // RULE2
      end else if (req_q) begin
        // power-up request: restart the delay timer
        reg_wait <= 1'b1; // RULE18
        reg_ps   <= '0;
        reg_us   <= 12'h000;
      end else if (reg_wait) begin
        if (reg_us >= reg_dly) begin
          reg_wait                     <= 1'b0;
          delayed_regulator_off_status <= 1'b0; // RULE2
        end else if (reg_ps == PS_LAST) begin
          reg_ps <= '0;
          reg_us <= reg_us + 12'h001;
        end else begin
          reg_ps <= reg_ps + PS_W'(1);
        end
      end
    end
  end

  // ==================================================================
  // rx/tx sequencer
  rrp_state_t      state;
  rrp_state_t      next_state;
  logic [PS_W-1:0] seq_ps;
  logic [11:0]     seq_us;
  logic [11:0]     lead_us;
  logic [11:0]     left_us;
  logic [11:0]     sw_lead;
  logic [11:0]     pa_lead;
  logic [11:0]     sw_tail;
  logic [11:0]     pa_tail;
  logic [11:0]     rx_wait_us;

  assign sw_lead    = {9'h000, switch_lead_time};
  assign pa_lead    = {8'h00, pa_on_lead_time};
  assign sw_tail    = {9'h000, tx_end_switch_off_time};
  assign pa_tail    = {9'h000, tx_end_pa_off_time};
  assign lead_us    = (sw_lead > pa_lead) ? sw_lead : pa_lead;
  assign left_us    = lead_us - seq_us;
  assign rx_wait_us = {9'h000, rx_chain_to_demod_time} * RX_STEP_US; // RULE4

  // next state; tx request wins over receive except when ST_TX_TAIL ends, regulator off wins all
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (tx_req) begin
          next_state = ST_TX_LEAD;
        end else if (rx_req) begin
          next_state = ST_RX_CAL;
        end
      end
      ST_RX_CAL: begin
        if (tx_req) begin
          next_state = ST_TX_LEAD;
        end else if (!rx_req) begin
          next_state = ST_IDLE;
        end else if (seq_us >= CAL_US) begin
          next_state = ST_RX_CHAIN; // RULE5
        end
      end
      ST_RX_CHAIN: begin
        if (tx_req) begin
          next_state = ST_TX_LEAD;
        end else if (!rx_req) begin
          next_state = ST_IDLE;
        end else if (seq_us >= rx_wait_us) begin
          next_state = ST_RX_ON; // RULE4
        end
      end
      ST_RX_ON: begin
        if (tx_req) begin
          next_state = ST_TX_LEAD;
        end else if (!rx_req) begin
          next_state = ST_IDLE;
        end
      end
      ST_TX_LEAD: begin
        if (seq_us >= lead_us) begin
          next_state = ST_TX_ON;
        end
      end
      ST_TX_ON: begin
        if (tx_last_chip) begin
          next_state = ST_TX_TAIL;
        end
      end
      ST_TX_TAIL: begin
        if (seq_us >= sw_tail && seq_us >= pa_tail) begin
          next_state = rx_req ? ST_RX_CAL : ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (delayed_regulator_off_status) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // microsecond timer, restarted on every state entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_ps <= '0;
      seq_us <= 12'h000;
    end else if (next_state != state) begin
      seq_ps <= '0; // RULE18
      seq_us <= 12'h000;
    end else if (seq_ps == PS_LAST) begin
      seq_ps <= '0;
      if (seq_us != 12'hFFF) begin
        seq_us <= seq_us + 12'h001;
      end
    end else begin
      seq_ps <= seq_ps + PS_W'(1);
    end
  end

  // ==================================================================
  // sequenced control lines before masking
  logic sw_on;
  logic pa_on;
  logic mod_on;
  logic rx_on;
  logic rx_filt;
  logic reg_dn;

  assign sw_on   = (state == ST_TX_LEAD && left_us <= sw_lead) || // RULE6
                   state == ST_TX_ON ||
                   (state == ST_TX_TAIL && seq_us < sw_tail); // RULE8
  assign pa_on   = (state == ST_TX_LEAD && left_us <= pa_lead) || // RULE7
                   state == ST_TX_ON ||
                   (state == ST_TX_TAIL && seq_us < pa_tail); // RULE9
  assign mod_on  = state == ST_TX_ON ||
                   (state == ST_TX_TAIL && seq_us < pa_tail); // RULE9
  assign rx_on   = state == ST_RX_CHAIN || state == ST_RX_ON;
  assign rx_filt = rx_on || state == ST_RX_CAL;
  assign reg_dn  = delayed_regulator_off_status;

  // ==================================================================
  // sequenced and masked outputs from flops so the analog side sees no glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_chain_en           <= 1'b0;
      demod_agc_en          <= 1'b0;
      tx_en                 <= 1'b0;
      modulator_en          <= 1'b0;
      gain_amp_peak_reset_n <= 1'b0;
      pa_bias_switch_ctrl   <= 1'b0;
      rxtx_select           <= 1'b0;
      prescaler_off         <= 1'b1;
      pa_neg_path_off       <= 1'b1;
      pa_pos_path_off       <= 1'b1;
      up_mixer_off          <= 1'b1;
      tx_dac_off            <= 1'b1;
      filter_cal_osc_off    <= 1'b1;
      charge_pump_off       <= 1'b1;
      synth_vco_off         <= 1'b1;
      rx_converters_off     <= 1'b1;
      gain_amp_off          <= 1'b1;
      rx_filter_off         <= 1'b1;
      front_end_off         <= 1'b1;
    end else begin
      rx_chain_en           <= rx_on; // RULE5
      demod_agc_en          <= state == ST_RX_ON; // RULE4
      tx_en                 <= state == ST_TX_ON;
      modulator_en          <= mod_on;
      gain_amp_peak_reset_n <= rx_on & mskh[6]; // RULE10 RULE17
      pa_bias_switch_ctrl   <= sw_on & mskh[5]; // RULE11 RULE17
      rxtx_select           <= sw_on & mskh[4]; // RULE12 RULE17
      prescaler_off         <= reg_dn & mskh[3]; // RULE14 RULE17
      pa_neg_path_off       <= ~pa_on & mskh[2]; // RULE13 RULE17
      pa_pos_path_off       <= ~pa_on & mskh[1]; // RULE13 RULE17
      up_mixer_off          <= ~pa_on & mskh[2] & mskh[1]; // RULE13
      tx_dac_off            <= ~mod_on & mskh[0]; // RULE14 RULE17
      filter_cal_osc_off    <= (state != ST_RX_CAL) & mskl[6]; // RULE15
      charge_pump_off       <= reg_dn & mskl[5]; // RULE15 RULE17
      synth_vco_off         <= reg_dn & mskl[4]; // RULE15 RULE17
      rx_converters_off     <= ~rx_on & mskl[3]; // RULE15 RULE17
      gain_amp_off          <= ~rx_on & mskl[2]; // RULE15 RULE17
      rx_filter_off         <= ~rx_filt & mskl[1]; // RULE15 RULE17
      front_end_off         <= ~rx_on & mskl[0]; // RULE15 RULE17
    end
  end

endmodule

`default_nettype wire

// file: rrp_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// pin checks of the sequencer
module rrp_seq_properties
  import rrp_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              regulator_off_request,
  input wire logic              delayed_regulator_off_status,
  input wire logic              rx_chain_en,
  input wire logic              demod_agc_en,
  input wire logic              tx_en,
  input wire logic              gain_amp_peak_reset_n,
  input wire logic              pa_bias_switch_ctrl,
  input wire logic              rxtx_select,
  input wire logic              prescaler_off,
  input wire logic              pa_neg_path_off,
  input wire logic              pa_pos_path_off,
  input wire logic              up_mixer_off,
  input wire logic              tx_dac_off,
  input wire logic              filter_cal_osc_off,
  input wire logic              charge_pump_off,
  input wire logic              synth_vco_off,
  input wire logic              rx_converters_off,
  input wire logic              gain_amp_off,
  input wire logic              rx_filter_off,
  input wire logic              front_end_off
);
  logic       wr;
  logic       req_sh;
  logic [7:0] mh;
  logic [7:0] ml;
  logic [6:0] hi_lines;
  logic [6:0] lo_lines;
  // gated lines grouped in mask bit order
  assign wr = psel && penable && pwrite;
  assign hi_lines = {gain_amp_peak_reset_n, pa_bias_switch_ctrl, rxtx_select, prescaler_off,
                     pa_neg_path_off, pa_pos_path_off, tx_dac_off};
  assign lo_lines = {filter_cal_osc_off, charge_pump_off, synth_vco_off, rx_converters_off,
                     gain_amp_off, rx_filter_off, front_end_off};
  // mask shadows, so gating is judged at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_sh <= RST_REQ;
      mh     <= RST_MSKH;
      ml     <= RST_MSKL;
    end else if (wr) begin
      if (paddr == {IDX_PWR, 2'b00}) req_sh <= pwdata[PWR_REQ];
      if (paddr == {IDX_MSKH, 2'b00}) mh <= pwdata[7:0];
      if (paddr == {IDX_MSKL, 2'b00}) ml <= pwdata[7:0];
    end
  end
  // ==================================================================
  // assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reserved_zero:
    assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0
      && (paddr != {IDX_PWR, 2'b00} || prdata[7:5] == 3'h0) && (paddr != {IDX_MSKL, 2'b00} || !prdata[7]))
    else $error("reserved read bits not zero");
  a_req_track:
    assert property (req_sh != regulator_off_request |-> ##[1:2] req_sh == regulator_off_request)
    else $error("request off its bit");
  a_status_fast:
    assert property ($rose(regulator_off_request) |-> ##[0:2] delayed_regulator_off_status)
    else $error("power-down status late");
  a_status_gap:
    assert property ($fell(delayed_regulator_off_status) |-> !regulator_off_request)
    else $error("status cleared while off");
  a_off_idle:
    assert property (delayed_regulator_off_status [*3] |-> !tx_en && !rx_chain_en && !demod_agc_en)
    else $error("active while off");
  a_mixer_pair:
    assert property ($stable({pa_neg_path_off, pa_pos_path_off}) [*2]
      |-> up_mixer_off == (pa_neg_path_off && pa_pos_path_off))
    else $error("mixer not tied to pa paths");
  a_gate_low:
    assert property ($stable(ml) [*3] |-> (lo_lines & ~ml[6:0]) == 7'h00)
    else $error("low mask not gating");
  a_gate_high:
    assert property ($stable(mh) [*3] |-> (hi_lines & ~{mh[7], mh[5:0]}) == 7'h00)
    else $error("high mask not gating");
  a_tx_lead:
    assert property ($rose(tx_en) |-> !pa_pos_path_off && !pa_neg_path_off && (rxtx_select || !mh[4]))
    else $error("pa or switch late");
  a_demod_order:
    assert property ($rose(demod_agc_en) |-> $past(rx_chain_en))
    else $error("demod before rx chain");
  a_cal_first:
    assert property ($rose(rx_chain_en) |-> $past(!filter_cal_osc_off))
    else $error("rx chain before cal");
  c_tx_run: cover property ($rose(tx_en));
  c_rx_run: cover property ($rose(demod_agc_en));
  c_reg_on: cover property ($fell(delayed_regulator_off_status));
endmodule

bind rrp_radio_power_seq rrp_seq_properties chk_u (.*);
`default_nettype wire

// file: rrp_front_end_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// transmit stand-in: last chip after chip_cycles
module rrp_front_end_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_en,
  input  wire logic [7:0] chip_cycles,
  output logic            tx_last_chip
);
  logic [7:0] sent;
  // counts modulated cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent         <= 8'h00;
      tx_last_chip <= 1'b0;
    end else begin
      sent         <= tx_en ? sent + 8'h01 : 8'h00;
      tx_last_chip <= tx_en && (sent == chip_cycles);
    end
  end
endmodule
`default_nettype wire

// file: radio_power_sequencing_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// sequencer bench
module radio_power_sequencing_control_tb_top;
  import rrp_pkg::*;
  localparam int US = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        rx_req = 1'b0;
  logic        tx_req = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  chip_len = 8'h20;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, tx_last_chip, regulator_off_request, delayed_regulator_off_status, er, st_exp;
  logic        rx_chain_en, demod_agc_en, tx_en, modulator_en, gain_amp_peak_reset_n, pa_bias_switch_ctrl;
  logic        rxtx_select, prescaler_off, pa_neg_path_off, pa_pos_path_off, up_mixer_off, tx_dac_off;
  logic        filter_cal_osc_off, charge_pump_off, synth_vco_off, rx_converters_off, gain_amp_off;
  logic        rx_filter_off, front_end_off;
  logic [6:0]  cur;
  logic [6:0]  prv = 7'h00;
  logic [15:0] lf;
  logic [7:0]  mdl [5] = '{8'h1C, 8'h7A, 8'h94, 8'hBF, 8'h7F};
  logic [7:0]  wm [5] = '{8'h0F, 8'hFF, 8'hFF, 8'hBF, 8'h7F};
  logic [17:0] adr [5] = '{{IDX_PWR, 2'b00}, {IDX_TMH, 2'b00}, {IDX_TML, 2'b00}, {IDX_MSKH, 2'b00}, {IDX_MSKL, 2'b00}};
  int          st [14];
  int          cyc = 0;
  int          bad_count = 0;
  int          comparisons = 0;
  int          tw, t0, j;
  always #2 pclk = ~pclk;
  rrp_radio_power_seq #(.US_CYCLES(US)) dut_u (.*);
  rrp_front_end_model fe_u (.pclk, .presetn, .tx_en, .chip_cycles(chip_len), .tx_last_chip);
  // ==================================================================
  // edge stamps: index 2*k+1 marks a rise, 2*k a fall of cur[k]
  assign cur = {delayed_regulator_off_status, rx_chain_en, demod_agc_en, rxtx_select, !pa_pos_path_off, tx_en,
                tx_last_chip};
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    prv <= cur;
    for (int k = 0; k < 7; k++) if (presetn && cur[k] !== prv[k]) st[2 * k + cur[k]] <= cyc;
  end
  // ==================================================================
  // helpers
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // timings allow some pipeline lag
  task automatic tchk(input string nm, input int seen, input int ex, input int tol);
    chk(nm, (seen >= ex - tol && seen <= ex + tol) ? ex : seen, ex);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic clear();
    foreach (st[i]) st[i] = -1;
  endtask
  task automatic wait_stamp(input int k);
    for (int n = 0; n < 3000 && st[k] < 0; n++) @(posedge pclk);
    if (st[k] < 0) begin
      bad_count++;
      $display("[ERR] event %0d expected seen none", k);
      conclude();
    end
  endtask
  // apb transfer held until pready sampled high
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      bad_count++;
      $display("[ERR] pready expected 1 seen 0");
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr_reg(input int k, input logic [7:0] d);
    apb(1'b1, adr[k], {24'h0, d}, rd, er);
    mdl[k] = d & wm[k];
    if (k == 0) st_exp = d[3] ? 1'b1 : st_exp;
  endtask
  task automatic rd_chk(input int k);
    apb(1'b0, adr[k], 32'h0, rd, er);
    chk($sformatf("register %0d", k), rd, {24'h0, mdl[k] | ((k == 0 && st_exp) ? 8'h10 : 8'h00)});
  endtask
  // ==================================================================
  // main sequence
  initial begin
    st_exp = 1'b1;
    lf = 16'h2121;
    clear();
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (j = 0; j < 5; j++) rd_chk(j);
    apb(1'b0, {16'hDF18, 2'b00}, 32'h0, rd, er);
    chk("unmapped error", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset values done");
    // writes to reserved and status bits, then power-up
    lf = lfsr_step(lf);
    wr_reg(0, 8'hF8 | lf[7:0]);
    rd_chk(0);
    clear();
    wr_reg(0, 8'h01);
    tw = cyc;
    wait_stamp(12);
    tchk("power-on delay", st[12] - tw, 31 * US, 6);
    st_exp = 1'b0;
    chk("request line", regulator_off_request, 32'h0);
    rd_chk(0);
    $display("test regulator done");
    // random timing fields, masks fully open
    lf = lfsr_step(lf);
    for (j = 1; j < 5; j++) wr_reg(j, j < 3 ? lf[8 * j - 8 +: 8] : 8'hFF);
    for (j = 1; j < 5; j++) rd_chk(j);
    // receive: calibration, then demod wait
    clear();
    rx_req <= 1'b1;
    t0 = cyc;
    wait_stamp(11);
    tchk("calibration", st[11] - t0, 104 * US, 4);
    wait_stamp(9);
    tchk("demod delay", st[9] - st[11], mdl[1][7:5] * 5 * US, 3);
    lf = lfsr_step(lf);
    wr_reg(3, lf[7:0]);
    wr_reg(4, lf[15:8]);
    rd_chk(3);
    rd_chk(4);
    wr_reg(3, 8'hFF);
    wr_reg(4, 8'hFF);
    rx_req <= 1'b0;
    wait_stamp(10);
    $display("test receive done");
    // transmit: lead and tail times
    clear();
    lf = lfsr_step(lf);
    chip_len <= {lf[5:0], 2'b01};
    tx_req <= 1'b1;
    @(posedge pclk);
    tx_req <= 1'b0;
    wait_stamp(3);
    chk("modulator on", modulator_en, 32'h1);
    tchk("switch lead", st[3] - st[7], mdl[1][4:2] * US, 2);
    tchk("pa lead", st[3] - st[5], {mdl[1][1:0], mdl[2][7:6]} * US, 2);
    wait_stamp(1);
    wait_stamp(6);
    wait_stamp(4);
    chk("modulator off", modulator_en, 32'h0);
    tchk("switch tail", st[6] - st[1], mdl[2][5:3] * US, 3);
    tchk("pa tail", st[4] - st[1], mdl[2][2:0] * US, 3);
    $display("test transmit done");
    // power-down shows at once
    clear();
    wr_reg(0, 8'h09);
    tw = cyc;
    wait_stamp(13);
    tchk("power-down lag", st[13] - tw, 2, 2);
    chk("request line", regulator_off_request, 32'h1);
    rd_chk(0);
    $display("test power-down done");
    conclude();
  end
endmodule
`default_nettype wire
